// ---- src/cap_defines.vh ----
// Constants shared by the console automation panel controller.
`ifndef CAP_DEFINES_VH
`define CAP_DEFINES_VH
// Functional notes
// - Short solo press toggles latch; held over one second, solo drops on release.
// - Without add mode a new solo cancels the previously active solos.
// - Solos switched on within a short window all stay on together.
// - Add mode defeats cancelling; input solos mask matrix solos while active.
// - Lock switch toggles lock state; lock lamp lit while locked.
// - While locked, assignments stay frozen and the virtual fader cannot be toggled.
// - Ninety seconds without assignment activity relocks; each operation restarts it.
// - Gain group, mute and fader mode switches are mutually exclusive.
// - Mute and gain group held together over half a second enables both.
// - Long group key press adds the group; short press selects only it, or clears it if it was the only one selected.
// - Long set press replaces channel groups; short press toggles selected groups.
// - Virtual fader works only at recall level or above.
// - With no groups selected, long set press clears assignments of active modes.
// - Per system lamp: green active, off inactive, red faulty.
// - Stores go to both systems; the selector picks the driving system.
// - Ten fast scene keys recall bound snapshots; in copy mode they bind.
// - Next, last and now recall following, preceding and displayed snapshot.
// - Four access levels gate assignment, recall, storage and editing.
// - Store writes current settings into the displayed snapshot number.
// - Insert places at displayed number and bumps that and later scenes; the code bumps only numbers sharing the displayed upper byte.
// - Copy takes displayed snapshot into a buffer; delete erases it.
// - Check previews snapshots without applying them, stepping with navigation keys.
`define CAP_TICK_CYC 17'h186A0
`define CAP_DEB_MS 4'hA
`define CAP_LONG_S 10'h001
`define CAP_MS_PER_S 17'h003E8
`define CAP_LONG_MS (`CAP_LONG_S * 10'h3E8)
`define CAP_BOTH_MS 10'h1F4
`define CAP_WIN_MS 6'h32
`define CAP_IDLE_S 17'h0005A
`define CAP_IDLE_MS (`CAP_IDLE_S * `CAP_MS_PER_S)
`define CAP_LVL_TOTAL 2'h0
`define CAP_LVL_RECALL 2'h1
`define CAP_LVL_STORE 2'h2
`define CAP_LVL_FULL 2'h3
`define CAP_OP_RECALL 3'h0
`define CAP_OP_STORE 3'h1
`define CAP_OP_INSERT 3'h2
`define CAP_OP_DELETE 3'h3
`define CAP_OP_COPY 3'h4
`define CAP_OP_PREVIEW 3'h5
`define CAP_A_CTRL 8'h00
`define CAP_A_STAT 8'h04
`define CAP_A_SOLO 8'h08
`define CAP_A_DISP 8'h0C
`define CAP_A_GROUP 8'h10
`define CAP_CTRL_ADD 0
`define CAP_CTRL_LVL 2:1
`define CAP_NSW 51
`define CAP_SW_SOLO 0
`define CAP_SW_LOCK 8
`define CAP_SW_MGAIN 9
`define CAP_SW_MMUTE 10
`define CAP_SW_MFAD 11
`define CAP_SW_ASG 12
`define CAP_SW_SET 20
`define CAP_SW_VF 28
`define CAP_SW_AB 29
`define CAP_SW_FAST 30
`define CAP_SW_NEXT 40
`define CAP_SW_LAST 41
`define CAP_SW_NOW 42
`define CAP_SW_STORE 43
`define CAP_SW_INS 44
`define CAP_SW_COPY 45
`define CAP_SW_DEL 46
`define CAP_SW_CHECK 47
`define CAP_SW_ACTSC 48
`define CAP_SW_UP 49
`define CAP_SW_DOWN 50
`define CAP_NDIR 16
`endif

// ---- src/cap_switch.v ----
// Debounce and press-duration timing for one panel switch.
`timescale 1ns/10ps
`include "cap_defines.vh"
module cap_switch (
  input wire hclk,
  input wire hresetn,
  input wire tick,
  input wire raw,
  output reg level_q,
  output reg press_q,
  output reg release_q,
  output reg long_q
);
  reg [3:0] deb_q;
  reg [9:0] hold_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      level_q <= 1'h0;
      press_q <= 1'h0;
      release_q <= 1'h0;
      long_q <= 1'h0;
      deb_q <= 4'h0;
      hold_q <= 10'h000;
    end else begin
      press_q <= 1'h0;
      release_q <= 1'h0;
      // A level must stay changed for a whole debounce span before it counts.
      if (raw == level_q) begin
        deb_q <= 4'h0;
      end else if (tick) begin
        if (deb_q == `CAP_DEB_MS - 4'h1) begin
          level_q <= raw;
          press_q <= raw;
          release_q <= ~raw;
          deb_q <= 4'h0;
        end else begin
          deb_q <= deb_q + 4'h1;
        end
      end
      // The long flag survives into the release pulse cycle.
      if (!level_q) begin
        hold_q <= 10'h000;
        long_q <= 1'h0;
      end else begin
        if (tick && hold_q != `CAP_LONG_MS) begin
          hold_q <= hold_q + 10'h001;
        end
        long_q <= (hold_q == `CAP_LONG_MS);
      end
    end
  end
endmodule // cap_switch

// ---- src/cap_panel_ctrl.v ----
// Automation panel controller with AHB-Lite register slave.
//
// The address map and the AHB-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "cap_defines.vh"
module cap_panel_ctrl #(
  parameter [16:0] TICK_CYCLES = `CAP_TICK_CYC
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  input wire [7:0] sw_solo,
  input wire sw_lock,
  input wire sw_mode_gain,
  input wire sw_mode_mute,
  input wire sw_mode_fader,
  input wire [7:0] sw_assign,
  input wire [7:0] sw_set,
  input wire sw_vfader,
  input wire sw_ab,
  input wire [9:0] sw_fast,
  input wire sw_next,
  input wire sw_last,
  input wire sw_now,
  input wire sw_store,
  input wire sw_insert,
  input wire sw_copy,
  input wire sw_delete,
  input wire sw_check,
  input wire sw_act_scene,
  input wire sw_up,
  input wire sw_down,
  input wire in_solo_on,
  input wire [1:0] sys_ok,
  output reg [7:0] solo_q,
  output reg lock_q,
  output reg mode_gain_q,
  output reg mode_mute_q,
  output reg mode_fader_q,
  output reg [7:0] group_sel_q,
  output reg [63:0] gain_asg_q,
  output reg [63:0] mute_asg_q,
  output reg vfader_en_q,
  output reg ab_sel_q,
  output reg [1:0] sys_green_q,
  output reg [1:0] sys_red_q,
  output reg act_sel_q,
  output reg check_q,
  output reg copy_q,
  output reg [15:0] disp_q,
  output reg snap_stb_q,
  output reg [2:0] snap_op_q,
  output reg [15:0] snap_num_q,
  output reg [1:0] snap_sys_q,
  output reg snap_from_buf_q
);
  ////////////////////////////////////////////////////////////////////////////
  wire [`CAP_NSW-1:0] raw;
  wire [`CAP_NSW-1:0] lvl;
  wire [`CAP_NSW-1:0] prs;
  wire [`CAP_NSW-1:0] rel;
  wire [`CAP_NSW-1:0] lng;
  reg [16:0] tick_cnt_q;
  reg tick_q;
  assign raw = {sw_down, sw_up, sw_act_scene, sw_check, sw_delete, sw_copy,
    sw_insert, sw_store, sw_now, sw_last, sw_next, sw_fast, sw_ab, sw_vfader,
    sw_set, sw_assign, sw_mode_fader, sw_mode_mute, sw_mode_gain, sw_lock,
    sw_solo};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tick_cnt_q <= 17'h00000;
      tick_q <= 1'h0;
    end else begin
      tick_q <= (tick_cnt_q == TICK_CYCLES - 17'h00001);
      if (tick_cnt_q == TICK_CYCLES - 17'h00001) begin
        tick_cnt_q <= 17'h00000;
      end else begin
        tick_cnt_q <= tick_cnt_q + 17'h00001;
      end
    end
  end
  genvar g;
  generate
    for (g = 0; g < `CAP_NSW; g = g + 1) begin : g_sw
      cap_switch u_sw (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick_q),
        .raw(raw[g]),
        .level_q(lvl[g]),
        .press_q(prs[g]),
        .release_q(rel[g]),
        .long_q(lng[g])
      );
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////
  reg add_mode_q;
  reg [1:0] lvl_q;
  wire lvl_rcl = (lvl_q >= `CAP_LVL_RECALL);
  wire lvl_sto = (lvl_q >= `CAP_LVL_STORE);
  wire asg_ok = ~lock_q & lvl_rcl;
  wire asg_mode = mode_gain_q | mode_mute_q;
  wire ap = hsel & htrans[1] & hready;
  reg wr_q;
  reg [7:0] adr_q;
  reg [31:0] rd_d;
  wire wr_disp = wr_q & (adr_q == `CAP_A_DISP);
  always @* begin
    case (haddr[7:0])
      `CAP_A_CTRL: rd_d = {29'h0, lvl_q, add_mode_q};
      `CAP_A_STAT: rd_d = {22'h0, copy_q, check_q, act_sel_q, ab_sel_q,
        vfader_en_q, mode_fader_q, mode_mute_q, mode_gain_q, lock_q, 1'h0};
      `CAP_A_SOLO: rd_d = {24'h0, solo_q};
      `CAP_A_DISP: rd_d = {16'h0, disp_q};
      `CAP_A_GROUP: rd_d = {24'h0, group_sel_q};
      default: rd_d = 32'h0;
    endcase
  end
  // Zero wait states; read data is sampled at the address phase.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'h1;
      hresp <= 1'h0;
      hrdata <= 32'h0;
      wr_q <= 1'h0;
      adr_q <= 8'h00;
      add_mode_q <= 1'h0;
      lvl_q <= `CAP_LVL_TOTAL;
    end else begin
      hreadyout <= 1'h1;
      hresp <= 1'h0;
      wr_q <= ap & hwrite;
      if (ap) begin
        adr_q <= haddr[7:0];
        hrdata <= hwrite ? 32'h0 : rd_d;
      end
      if (wr_q && adr_q == `CAP_A_CTRL) begin
        add_mode_q <= hwdata[`CAP_CTRL_ADD];
        lvl_q <= hwdata[`CAP_CTRL_LVL];
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  reg [7:0] lat_q;
  reg [7:0] lat_d;
  reg [5:0] win_q;
  reg in_solo_q;
  wire [7:0] s_prs = prs[`CAP_SW_SOLO +: 8];
  wire [7:0] s_new = s_prs & ~lat_q;
  wire cancel_ok = ~add_mode_q & (win_q == 6'h00);
  integer k;
  always @* begin
    lat_d = lat_q ^ s_prs;
    if (|s_new && cancel_ok) begin
      lat_d = s_new;
    end
    if (in_solo_on && !in_solo_q && cancel_ok) begin
      lat_d = 8'h00;
    end
    lat_d = lat_d & ~(rel[`CAP_SW_SOLO +: 8] & lng[`CAP_SW_SOLO +: 8]);
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lat_q <= 8'h00;
      solo_q <= 8'h00;
      win_q <= 6'h00;
      in_solo_q <= 1'h0;
    end else begin
      in_solo_q <= in_solo_on;
      lat_q <= lat_d;
      // In add mode matrix solos only step aside, so they return when inputs clear.
      solo_q <= lat_d & ~{8{add_mode_q & in_solo_on}};
      if (|s_new) begin
        win_q <= `CAP_WIN_MS;
      end else if (tick_q && win_q != 6'h00) begin
        win_q <= win_q - 6'h01;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  reg [16:0] idle_q;
  reg [9:0] both_q;
  reg [7:0] grp_d;
  reg [63:0] gain_d;
  reg [63:0] mute_d;
  wire asg_act = |prs[`CAP_SW_MFAD:`CAP_SW_MGAIN] |
    |prs[`CAP_SW_VF:`CAP_SW_ASG];
  always @* begin
    grp_d = group_sel_q;
    gain_d = gain_asg_q;
    mute_d = mute_asg_q;
    for (k = 0; k < 8; k = k + 1) begin
      if (asg_ok && asg_mode && rel[`CAP_SW_ASG + k]) begin
        if (lng[`CAP_SW_ASG + k]) begin
          grp_d[k] = 1'h1;
        end else if (group_sel_q == (8'h01 << k)) begin
          grp_d = 8'h00;
        end else begin
          grp_d = 8'h01 << k;
        end
      end
      if (asg_ok && asg_mode && rel[`CAP_SW_SET + k]) begin
        if (group_sel_q != 8'h00) begin
          if (lng[`CAP_SW_SET + k]) begin
            if (mode_gain_q) gain_d[k*8 +: 8] = group_sel_q;
            if (mode_mute_q) mute_d[k*8 +: 8] = group_sel_q;
          end else begin
            if (mode_gain_q) gain_d[k*8 +: 8] = gain_d[k*8 +: 8] ^ group_sel_q;
            if (mode_mute_q) mute_d[k*8 +: 8] = mute_d[k*8 +: 8] ^ group_sel_q;
          end
        end else if (lng[`CAP_SW_SET + k]) begin
          if (mode_gain_q) gain_d[k*8 +: 8] = 8'h00;
          if (mode_mute_q) mute_d[k*8 +: 8] = 8'h00;
        end
      end
    end
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      lock_q <= 1'h1;
      idle_q <= 17'h00000;
      both_q <= 10'h000;
      mode_gain_q <= 1'h1;
      mode_mute_q <= 1'h0;
      mode_fader_q <= 1'h0;
      group_sel_q <= 8'h00;
      gain_asg_q <= 64'h0;
      mute_asg_q <= 64'h0;
      vfader_en_q <= 1'h0;
      ab_sel_q <= 1'h0;
      sys_green_q <= 2'h0;
      sys_red_q <= 2'h0;
    end else begin
      if (prs[`CAP_SW_LOCK]) begin
        lock_q <= ~lock_q;
      end else if (!lock_q && !asg_act && tick_q &&
          idle_q == `CAP_IDLE_MS - 17'h00001) begin
        lock_q <= 1'h1;
      end
      if (lock_q || asg_act) begin
        idle_q <= 17'h00000;
      end else if (tick_q) begin
        idle_q <= idle_q + 17'h00001;
      end
      // Holding both keys opens the interlock so gain and mute modes run together.
      if (lvl[`CAP_SW_MGAIN] && lvl[`CAP_SW_MMUTE]) begin
        if (tick_q && both_q != `CAP_BOTH_MS) begin
          both_q <= both_q + 10'h001;
        end
      end else begin
        both_q <= 10'h000;
      end
      if (both_q == `CAP_BOTH_MS) begin
        mode_gain_q <= 1'h1;
        mode_mute_q <= 1'h1;
        mode_fader_q <= 1'h0;
      end else if (prs[`CAP_SW_MGAIN]) begin
        {mode_gain_q, mode_mute_q, mode_fader_q} <= 3'h4;
      end else if (prs[`CAP_SW_MMUTE]) begin
        {mode_gain_q, mode_mute_q, mode_fader_q} <= 3'h2;
      end else if (prs[`CAP_SW_MFAD]) begin
        {mode_gain_q, mode_mute_q, mode_fader_q} <= 3'h1;
      end
      group_sel_q <= grp_d;
      gain_asg_q <= gain_d;
      mute_asg_q <= mute_d;
      if (!lvl_rcl) begin
        vfader_en_q <= 1'h0;
      end else if (prs[`CAP_SW_VF] && !lock_q) begin
        vfader_en_q <= ~vfader_en_q;
      end
      if (prs[`CAP_SW_AB]) begin
        ab_sel_q <= ~ab_sel_q;
      end
      sys_green_q <= sys_ok & {ab_sel_q, ~ab_sel_q};
      sys_red_q <= ~sys_ok;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  reg [15:0] dir_num [0:`CAP_NDIR-1];
  reg [`CAP_NDIR-1:0] dir_vld;
  reg [15:0] fast_num [0:9];
  reg [9:0] fast_vld;
  reg [15:0] rec_q;
  reg [15:0] copy_buf_q;
  reg pend_q;
  reg hit_ok, free_ok, nxt_ok, lst_ok;
  reg [3:0] hit_ix, free_ix;
  reg [15:0] nxt, lst;
  integer i;
  integer j;
  always @* begin
    hit_ok = 1'h0;
    free_ok = 1'h0;
    nxt_ok = 1'h0;
    lst_ok = 1'h0;
    hit_ix = 4'h0;
    free_ix = 4'h0;
    nxt = 16'hFFFF;
    lst = 16'h0000;
    for (j = `CAP_NDIR - 1; j >= 0; j = j - 1) begin
      if (!dir_vld[j]) begin
        free_ok = 1'h1;
        free_ix = j[3:0];
      end else begin
        if (dir_num[j] == disp_q) begin
          hit_ok = 1'h1;
          hit_ix = j[3:0];
        end
        if (dir_num[j] > rec_q && dir_num[j] <= nxt) begin
          nxt_ok = 1'h1;
          nxt = dir_num[j];
        end
        if (dir_num[j] < rec_q && dir_num[j] >= lst) begin
          lst_ok = 1'h1;
          lst = dir_num[j];
        end
      end
    end
  end
  wire [15:0] step = act_sel_q ? 16'h0100 : 16'h0001;
  wire [2:0] rcl_op = check_q ? `CAP_OP_PREVIEW : `CAP_OP_RECALL;
  wire [1:0] act_sys = {ab_sel_q, ~ab_sel_q};
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (i = 0; i < `CAP_NDIR; i = i + 1) dir_num[i] <= 16'h0000;
      for (i = 0; i < 10; i = i + 1) fast_num[i] <= 16'h0000;
      dir_vld <= 16'h0000;
      fast_vld <= 10'h000;
      rec_q <= 16'h0000;
      copy_buf_q <= 16'h0000;
      pend_q <= 1'h0;
      disp_q <= 16'h0000;
      act_sel_q <= 1'h0;
      check_q <= 1'h0;
      copy_q <= 1'h0;
      snap_stb_q <= 1'h0;
      snap_op_q <= `CAP_OP_RECALL;
      snap_num_q <= 16'h0000;
      snap_sys_q <= 2'h0;
      snap_from_buf_q <= 1'h0;
    end else begin
      snap_stb_q <= 1'h0;
      pend_q <= 1'h0;
      snap_sys_q <= act_sys;
      snap_from_buf_q <= 1'h0;
      if (prs[`CAP_SW_ACTSC]) act_sel_q <= ~act_sel_q;
      if (wr_disp) begin
        disp_q <= hwdata[15:0];
      end else if (prs[`CAP_SW_UP]) begin
        disp_q <= disp_q + step;
        pend_q <= check_q;
      end else if (prs[`CAP_SW_DOWN]) begin
        disp_q <= disp_q - step;
        pend_q <= check_q;
      end
      for (i = 0; i < 10; i = i + 1) begin
        if (prs[`CAP_SW_FAST + i] && lvl_rcl) begin
          if (copy_q) begin
            fast_num[i] <= copy_buf_q;
            fast_vld[i] <= 1'h1;
            copy_q <= 1'h0;
          end else if (fast_vld[i]) begin
            snap_stb_q <= 1'h1;
            snap_op_q <= rcl_op;
            snap_num_q <= fast_num[i];
            if (!check_q) rec_q <= fast_num[i];
          end
        end
      end
      // Previews never move the recalled position; they only strobe a preview command.
      if (pend_q) begin
        snap_stb_q <= 1'h1;
        snap_op_q <= `CAP_OP_PREVIEW;
        snap_num_q <= disp_q;
      end else if (prs[`CAP_SW_CHECK] && lvl_rcl) begin
        check_q <= ~check_q;
        pend_q <= ~check_q;
      end else if (lvl_rcl && ((prs[`CAP_SW_NEXT] && nxt_ok) ||
          (prs[`CAP_SW_LAST] && lst_ok) || prs[`CAP_SW_NOW])) begin
        snap_stb_q <= 1'h1;
        snap_op_q <= rcl_op;
        snap_num_q <= prs[`CAP_SW_NEXT] ? nxt :
          (prs[`CAP_SW_LAST] ? lst : disp_q);
        if (!check_q) begin
          rec_q <= prs[`CAP_SW_NEXT] ? nxt :
            (prs[`CAP_SW_LAST] ? lst : disp_q);
        end
      end else if (lvl_sto && prs[`CAP_SW_STORE] && (hit_ok || free_ok)) begin
        dir_num[hit_ok ? hit_ix : free_ix] <= disp_q;
        dir_vld[hit_ok ? hit_ix : free_ix] <= 1'h1;
        snap_stb_q <= 1'h1;
        snap_op_q <= `CAP_OP_STORE;
        snap_num_q <= disp_q;
        snap_sys_q <= 2'h3;
        snap_from_buf_q <= copy_q;
        copy_q <= 1'h0;
        rec_q <= disp_q;
      end else if (lvl_sto && prs[`CAP_SW_INS] && free_ok) begin
        for (i = 0; i < `CAP_NDIR; i = i + 1) begin
          if (dir_vld[i] && dir_num[i][15:8] == disp_q[15:8] &&
              dir_num[i][7:0] >= disp_q[7:0]) begin
            dir_num[i] <= dir_num[i] + 16'h0001;
          end
        end
        dir_num[free_ix] <= disp_q;
        dir_vld[free_ix] <= 1'h1;
        snap_stb_q <= 1'h1;
        snap_op_q <= `CAP_OP_INSERT;
        snap_num_q <= disp_q;
        snap_sys_q <= 2'h3;
        snap_from_buf_q <= copy_q;
        copy_q <= 1'h0;
      end else if (lvl_sto && prs[`CAP_SW_COPY] && hit_ok) begin
        copy_buf_q <= disp_q;
        copy_q <= 1'h1;
        snap_stb_q <= 1'h1;
        snap_op_q <= `CAP_OP_COPY;
        snap_num_q <= disp_q;
      end else if (lvl_sto && prs[`CAP_SW_DEL] && hit_ok) begin
        dir_vld[hit_ix] <= 1'h0;
        snap_stb_q <= 1'h1;
        snap_op_q <= `CAP_OP_DELETE;
        snap_num_q <= disp_q;
        snap_sys_q <= 2'h3;
      end
    end
  end
endmodule // cap_panel_ctrl

// ---- tb/cap_panel_properties.sv ----
// Port-level assertions for the automation panel controller.
`timescale 1ns/10ps
`include "cap_defines.vh"
module cap_panel_properties #(
  parameter [16:0] TICK_CYCLES = `CAP_TICK_CYC
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  input wire sw_lock,
  input wire [1:0] sys_ok,
  input wire lock_q,
  input wire mode_gain_q,
  input wire mode_mute_q,
  input wire mode_fader_q,
  input wire [7:0] group_sel_q,
  input wire [63:0] gain_asg_q,
  input wire [63:0] mute_asg_q,
  input wire ab_sel_q,
  input wire [1:0] sys_green_q,
  input wire [1:0] sys_red_q,
  input wire [15:0] disp_q,
  input wire snap_stb_q,
  input wire [2:0] snap_op_q,
  input wire [15:0] snap_num_q,
  input wire [1:0] snap_sys_q
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Run length of the raw lock switch; a bounce restarts it.
  reg [19:0] lk_run_q;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) lk_run_q <= 20'h00000;
    else if (!sw_lock) lk_run_q <= 20'h00000;
    else if (lk_run_q != 20'hFFFFF) lk_run_q <= lk_run_q + 20'h00001;
  end
  ////////////////////////////////////////////////////////////
  property p_bus_okay;
    hreadyout && !hresp;
  endproperty
  a_bus_okay: assert property (p_bus_okay)
    else $error("bus answer not ready or not okay");
  property p_stat_lock;
    hsel && htrans[1] && hready && !hwrite && haddr[7:0] == `CAP_A_STAT
      |=> hrdata[1] == $past(lock_q);
  endproperty
  a_stat_lock: assert property (p_stat_lock)
    else $error("status read shows wrong lock state");
  property p_lock_debounce;
    $fell(lock_q) |-> lk_run_q >= 9 * TICK_CYCLES;
  endproperty
  a_lock_debounce: assert property (p_lock_debounce)
    else $error("unlocked without a debounced lock press");
  property p_lock_freeze;
    lock_q && $past(lock_q) && $past(lock_q, 2) |-> $stable(gain_asg_q)
      && $stable(mute_asg_q) && $stable(group_sel_q);
  endproperty
  a_lock_freeze: assert property (p_lock_freeze)
    else $error("assignment changed while locked");
  property p_mode_excl;
    !(mode_fader_q && (mode_gain_q || mode_mute_q));
  endproperty
  a_mode_excl: assert property (p_mode_excl)
    else $error("fader mode shown with another mode");
  property p_lamps;
    ($stable(sys_ok) && $stable(ab_sel_q))[*3] |-> sys_red_q == ~sys_ok
      && sys_green_q == (sys_ok & {ab_sel_q, !ab_sel_q});
  endproperty
  a_lamps: assert property (p_lamps)
    else $error("system lamps disagree with health");
  property p_snap_both;
    snap_stb_q && snap_op_q inside {`CAP_OP_STORE, `CAP_OP_INSERT,
      `CAP_OP_DELETE} |-> snap_sys_q == 2'h3;
  endproperty
  a_snap_both: assert property (p_snap_both)
    else $error("edit not sent to both systems");
  property p_snap_one;
    snap_stb_q && !(snap_op_q inside {`CAP_OP_STORE, `CAP_OP_INSERT,
      `CAP_OP_DELETE}) |-> snap_sys_q == {ab_sel_q, !ab_sel_q};
  endproperty
  a_snap_one: assert property (p_snap_one)
    else $error("read not aimed at the active system");
  property p_store_num;
    snap_stb_q && snap_op_q inside {`CAP_OP_STORE, `CAP_OP_INSERT}
      |-> snap_num_q == disp_q;
  endproperty
  a_store_num: assert property (p_store_num)
    else $error("store target differs from display");
  c_store: cover property (snap_stb_q && snap_op_q == `CAP_OP_STORE);
  c_unlock: cover property ($fell(lock_q));
  c_both: cover property (mode_gain_q && mode_mute_q);
endmodule // cap_panel_properties

bind cap_panel_ctrl cap_panel_properties #(.TICK_CYCLES(TICK_CYCLES)) u_props (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .sw_lock(sw_lock), .sys_ok(sys_ok), .lock_q(lock_q),
  .mode_gain_q(mode_gain_q), .mode_mute_q(mode_mute_q),
  .mode_fader_q(mode_fader_q), .group_sel_q(group_sel_q),
  .gain_asg_q(gain_asg_q), .mute_asg_q(mute_asg_q),
  .ab_sel_q(ab_sel_q), .sys_green_q(sys_green_q),
  .sys_red_q(sys_red_q), .disp_q(disp_q), .snap_stb_q(snap_stb_q),
  .snap_op_q(snap_op_q), .snap_num_q(snap_num_q),
  .snap_sys_q(snap_sys_q));

// ---- tb/cap_panel_model.sv ----
// Operator panel model: raw switch levels with contact bounce.
`timescale 1ns/10ps
module cap_panel_model #(
  parameter int TICK = 10
) (
  input wire hclk,
  output logic [50:0] sw_q
);
  initial sw_q = '0;
  // Real contacts chatter, so every press opens with a burst of bounce.
  task automatic press(input logic [50:0] m, input int ms);
    repeat (3) begin
      @(posedge hclk) sw_q <= sw_q | m;
      @(posedge hclk) sw_q <= sw_q & ~m;
    end
    @(posedge hclk) sw_q <= sw_q | m;
    repeat (ms * TICK) @(posedge hclk);
    sw_q <= sw_q & ~m;
    repeat (60 * TICK) @(posedge hclk);
  endtask
endmodule // cap_panel_model

// ---- tb/testbench.sv ----
// Self-checking bench for the automation panel controller.
`timescale 1ns/10ps
`include "cap_defines.vh"
`define CHK(a, e) check_val(64'(a), 64'(e))
module testbench;
  localparam int TK = 5;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, in_solo_on = 0;
  logic [31:0] haddr = '0, hwdata = '0, q;
  logic [1:0] htrans = '0, sys_ok = 2'h3;
  logic [20:0] snap;
  logic [50:0] sw;
  wire hreadyout, lock_q, mg, mm, mf, vf, ab, stb, chk;
  wire [31:0] hrdata;
  wire [7:0] solo_q, grp;
  wire [63:0] gain_asg, mute_asg;
  wire [1:0] green, red, ssys;
  wire [15:0] disp, snum;
  wire [2:0] sop;
  int errors = 0, samples_checked = 0, cyc = 0;
  always #5 hclk = ~hclk;
  cap_panel_model #(.TICK(TK)) i_panel (.hclk(hclk), .sw_q(sw));
  cap_panel_ctrl #(.TICK_CYCLES(17'(TK))) i_dut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(), .hrdata(hrdata),
    .sw_solo(sw[`CAP_SW_SOLO+:8]), .sw_lock(sw[`CAP_SW_LOCK]),
    .sw_mode_gain(sw[`CAP_SW_MGAIN]), .sw_mode_mute(sw[`CAP_SW_MMUTE]),
    .sw_mode_fader(sw[`CAP_SW_MFAD]), .sw_assign(sw[`CAP_SW_ASG+:8]),
    .sw_set(sw[`CAP_SW_SET+:8]), .sw_vfader(sw[`CAP_SW_VF]),
    .sw_ab(sw[`CAP_SW_AB]), .sw_fast(sw[`CAP_SW_FAST+:10]),
    .sw_next(sw[`CAP_SW_NEXT]), .sw_last(sw[`CAP_SW_LAST]),
    .sw_now(sw[`CAP_SW_NOW]), .sw_store(sw[`CAP_SW_STORE]),
    .sw_insert(sw[`CAP_SW_INS]), .sw_copy(sw[`CAP_SW_COPY]),
    .sw_delete(sw[`CAP_SW_DEL]), .sw_check(sw[`CAP_SW_CHECK]),
    .sw_act_scene(sw[`CAP_SW_ACTSC]), .sw_up(sw[`CAP_SW_UP]),
    .sw_down(sw[`CAP_SW_DOWN]), .in_solo_on(in_solo_on), .sys_ok(sys_ok),
    .solo_q(solo_q), .lock_q(lock_q), .mode_gain_q(mg), .mode_mute_q(mm),
    .mode_fader_q(mf), .group_sel_q(grp), .gain_asg_q(gain_asg),
    .mute_asg_q(mute_asg), .vfader_en_q(vf), .ab_sel_q(ab),
    .sys_green_q(green), .sys_red_q(red), .act_sel_q(), .check_q(chk),
    .copy_q(), .disp_q(disp), .snap_stb_q(stb), .snap_op_q(sop),
    .snap_num_q(snum), .snap_sys_q(ssys), .snap_from_buf_q());
  // The strobe lasts one cycle, so the last command is latched here.
  always @(posedge hclk) if (stb === 1'b1) snap <= {sop, snum, ssys};
  ////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 60000) begin
      errors++;
      print_verdict;
    end
  end
  task automatic check_val(input logic [63:0] a, input logic [63:0] e);
    samples_checked++;
    if (a !== e) begin
      errors++;
      $display("mismatch at %0t got %0h expected %0h", $time, a, e);
    end
  endtask
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h000000, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    `CHK(q, e);
  endtask
  task automatic p(input int i, input int ms);
    i_panel.press(51'(1) << i, ms);
  endtask
  initial begin
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`CAP_A_STAT, 32'h00000006);
    rd(8'h20, 32'h00000000);
    bus(1'b1, `CAP_A_CTRL, 32'h00000002);
    rd(`CAP_A_CTRL, 32'h00000002);
    p(`CAP_SW_SOLO, 30); `CHK(solo_q, 8'h01);
    p(`CAP_SW_SOLO + 1, 30); `CHK(solo_q, 8'h02);
    p(`CAP_SW_SOLO + 1, 30); `CHK(solo_q, 8'h00);
    i_panel.press(51'hC << `CAP_SW_SOLO, 30); `CHK(solo_q, 8'h0C);
    p(`CAP_SW_SOLO + 4, 1100); `CHK(solo_q, 8'h00);
    bus(1'b1, `CAP_A_CTRL, 32'h00000003);
    p(`CAP_SW_SOLO, 30);
    p(`CAP_SW_SOLO + 1, 30); `CHK(solo_q, 8'h03);
    in_solo_on <= 1'b1;
    repeat (10) @(posedge hclk); `CHK(solo_q, 8'h00);
    in_solo_on <= 1'b0;
    repeat (10) @(posedge hclk); `CHK(solo_q, 8'h03);
    rd(`CAP_A_SOLO, 32'h00000003);
    p(`CAP_SW_MMUTE, 30); `CHK({mg, mm, mf}, 3'h2);
    p(`CAP_SW_ASG + 1, 30); `CHK(grp, 8'h00);
    p(`CAP_SW_LOCK, 30); `CHK(lock_q, 1'b0);
    p(`CAP_SW_ASG + 1, 30); `CHK(grp, 8'h02);
    p(`CAP_SW_ASG + 2, 1100); `CHK(grp, 8'h06);
    p(`CAP_SW_SET, 30); `CHK(mute_asg[7:0], 8'h06);
    p(`CAP_SW_ASG + 2, 30); `CHK(grp, 8'h04);
    p(`CAP_SW_SET, 1100); `CHK(mute_asg[7:0], 8'h04);
    p(`CAP_SW_ASG + 2, 30); `CHK(grp, 8'h00);
    p(`CAP_SW_SET, 1100); `CHK(mute_asg, 64'h0);
    p(`CAP_SW_VF, 30); `CHK(vf, 1'b1);
    bus(1'b1, `CAP_A_CTRL, 32'h00000000);
    repeat (5) @(posedge hclk); `CHK(vf, 1'b0);
    i_panel.press(51'h3 << `CAP_SW_MGAIN, 600); `CHK({mg, mm}, 2'h3);
    sys_ok <= 2'h1;
    repeat (5) @(posedge hclk); `CHK({red, green}, 4'h9);
    sys_ok <= 2'h3;
    p(`CAP_SW_AB, 30); `CHK({ab, red, green}, 5'h12);
    bus(1'b1, `CAP_A_CTRL, 32'h00000004);
    bus(1'b1, `CAP_A_DISP, 32'h00000102);
    p(`CAP_SW_STORE, 30); `CHK(snap, {`CAP_OP_STORE, 18'h0040B});
    p(`CAP_SW_INS, 30); `CHK(snap, {`CAP_OP_INSERT, 18'h0040B});
    p(`CAP_SW_DEL, 30); `CHK(snap, {`CAP_OP_DELETE, 18'h0040B});
    p(`CAP_SW_NEXT, 30); `CHK(snap, {`CAP_OP_RECALL, 18'h0040E});
    p(`CAP_SW_CHECK, 30); `CHK(chk, 1'b1);
    rd(`CAP_A_STAT, 32'h0000014C);
    print_verdict;
  end
endmodule // testbench
